//--- hw/usdp_datapath.sv
`timescale 1ns/1ps
`include "usdp_defs.svh"
module usdp_datapath #(
  parameter int BAUD_W = 12
) (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            irq_tx_empty,
  output logic            irq_tx_complete,
  input  wire logic       irq_tx_complete_ack,
  input  wire logic       sync_clock_pin,
  input  wire logic       serial_in_pin,
  output logic            serial_out_pin,
  output logic            serial_out_oe,
  output logic            rx_pin_owned
);
  // ==========================================================
  // Helpers
  // Data bit count from the character size code
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    char_bits = (code == `USDP_SZ_NINE) ? 4'h9 : (4'h5 + {2'h0, code[1:0]});
  endfunction
  // Mask of valid data bits
  function automatic logic [8:0] char_mask(input logic [3:0] n);
    char_mask = 9'h1FF >> (4'h9 - n);
  endfunction
  // Parity of the masked data, inverted for odd
  function automatic logic par_bit(input logic [8:0] d, input logic [3:0] n,
                                   input logic odd);
    par_bit = (^(d & char_mask(n))) ^ odd;
  endfunction

  // ==========================================================
  // Control registers
  logic              double_speed_sel_ff;    // Halved divisor
  logic              tx_complete_irq_en_ff;  // Complete request enable
  logic              tx_buffer_empty_irq_en_ff; // Empty request enable
  logic              receiver_enable_ff;     // Receiver on
  logic              transmitter_enable_ff;  // Transmitter on
  logic              tx_ninth_bit_ff;        // Ninth transmit bit
  logic              sync_mode_ff;           // Synchronous operation
  logic [1:0]        parity_mode_field_ff;   // Enable and odd select
  logic              stop2_ff;               // Two stop bits sent
  logic [2:0]        char_size_code_ff;      // Character size code
  logic [BAUD_W-1:0] baud_ff;                // Baud divider setting
  logic [3:0]        nbits;                  // Data bits per frame
  logic              wr_data;                // Data location write
  logic              rd_data;                // Data location read

  assign nbits   = char_bits(char_size_code_ff);
  assign wr_data = reg_wr && (reg_addr == `USDP_ADDR_DATA);
  assign rd_data = reg_rd && (reg_addr == `USDP_ADDR_DATA);

  // Software writes to control fields
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      double_speed_sel_ff       <= 1'b0;
      tx_complete_irq_en_ff     <= 1'b0;
      tx_buffer_empty_irq_en_ff <= 1'b0;
      receiver_enable_ff        <= 1'b0;
      transmitter_enable_ff     <= 1'b0;
      tx_ninth_bit_ff           <= 1'b0;
      sync_mode_ff              <= 1'b0;
      parity_mode_field_ff      <= 2'h0;
      stop2_ff                  <= 1'b0;
      char_size_code_ff         <= `USDP_RST_SZ;
      baud_ff                   <= `USDP_RST_BAUD;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `USDP_ADDR_CSA: begin
          // Flag positions here are ignored on write, except TXC, where a one clears the complete flag
          double_speed_sel_ff <= reg_wdata[`USDP_CSA_U2X];
        end
        `USDP_ADDR_CSB: begin
          tx_complete_irq_en_ff     <= reg_wdata[`USDP_CSB_TX_COMPLETE_IRQ_EN];
          tx_buffer_empty_irq_en_ff <= reg_wdata[`USDP_CSB_TX_BUFFER_EMPTY_IRQ_EN];
          receiver_enable_ff        <= reg_wdata[`USDP_CSB_RECEIVER_ENABLE];
          transmitter_enable_ff     <= reg_wdata[`USDP_CSB_TRANSMITTER_ENABLE];
          char_size_code_ff[2]      <= reg_wdata[`USDP_CSB_SZ2];
          tx_ninth_bit_ff           <= reg_wdata[`USDP_CSB_TX_NINTH_BIT];
        end
        `USDP_ADDR_CSC: begin
          sync_mode_ff           <= reg_wdata[`USDP_CSC_SYNC];
          parity_mode_field_ff   <= reg_wdata[`USDP_CSC_PAR_EN:`USDP_CSC_PAR_ODD];
          stop2_ff               <= reg_wdata[`USDP_CSC_STOP2];
          char_size_code_ff[1:0] <= reg_wdata[`USDP_CSC_SZ_HI:`USDP_CSC_SZ_LO];
        end
        `USDP_ADDR_BAUD_LO: baud_ff[7:0] <= reg_wdata;
        `USDP_ADDR_BAUD_HI: baud_ff[BAUD_W-1:8] <= reg_wdata[BAUD_W-9:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Bit timing
  logic [BAUD_W+4:0] bit_period; // System clocks per sample
  logic              xck_q_ff;   // Previous clock pin level
  logic              xck_rise;   // Transmit change edge
  logic              xck_fall;   // Receive sample edge

  assign bit_period = {5'h00, baud_ff} + {{BAUD_W{1'b0}}, 5'h01};
  assign xck_rise   = sync_clock_pin && !xck_q_ff;
  assign xck_fall   = !sync_clock_pin && xck_q_ff;

  // Clock pin history for edge detection
  always_ff @(posedge core_clk) begin
    if (!resetn) xck_q_ff <= 1'b0;
    else         xck_q_ff <= sync_clock_pin;
  end

  // Full bit length in system clocks
  function automatic logic [BAUD_W+4:0] full_bit(input logic dbl,
                                                 input logic [BAUD_W+4:0] p);
    full_bit = dbl ? (p << `USDP_OVS_SHIFT_2X) : (p << `USDP_OVS_SHIFT_N);
  endfunction

  // ==========================================================
  // Transmitter
  usdp_pkg::usdp_tx_state_e tx_st_ff;
  logic [8:0]        txbuf_ff;       // Transmit buffer
  logic              txbuf_valid_ff; // Buffer holds unsent data
  logic [8:0]        txsh_ff;        // Transmit shift register
  logic [3:0]        tx_bit_ff;      // Data bits sent
  logic [BAUD_W+4:0] tx_cnt_ff;      // Bit timer
  logic              tx_on_ff;       // Transmitter owns the pin
  logic              tx_complete_flag_ff;
  logic              tx_tick;        // End of current bit
  logic              tx_load;        // Buffer moves to shifter
  logic              tx_frame_end;   // Last stop bit finished
  logic              tx_buffer_empty_flag;

  assign tx_buffer_empty_flag = !txbuf_valid_ff;
  assign tx_tick = sync_mode_ff ? xck_rise : (tx_cnt_ff == '0);
  assign tx_frame_end = tx_tick && ((tx_st_ff == usdp_pkg::TX_STOP2) ||
                        ((tx_st_ff == usdp_pkg::TX_STOP1) && !stop2_ff));
  assign tx_load = tx_on_ff && txbuf_valid_ff &&
                   ((tx_st_ff == usdp_pkg::TX_IDLE) || tx_frame_end);

  // Transmit buffer: data writes fill, shifter load empties
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      txbuf_ff       <= 9'h000;
      txbuf_valid_ff <= 1'b0;
    end else if (wr_data) begin
      // Upper bits dropped, ninth bit taken from control
      txbuf_ff <= {tx_ninth_bit_ff, reg_wdata} & char_mask(nbits);
      txbuf_valid_ff <= 1'b1;
    end else if (tx_load) begin
      txbuf_valid_ff <= 1'b0;
    end
  end

  // Frame sequencer
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tx_st_ff  <= usdp_pkg::TX_IDLE;
      txsh_ff   <= 9'h000;
      tx_bit_ff <= 4'h0;
      tx_cnt_ff <= '0;
    end else begin
      tx_cnt_ff <= (tx_tick || tx_load) ?
                   full_bit(double_speed_sel_ff, bit_period) - 1'b1 : tx_cnt_ff - 1'b1;
      if (tx_load) begin
        tx_st_ff  <= usdp_pkg::TX_START;
        txsh_ff   <= txbuf_ff;
        tx_bit_ff <= 4'h0;
      end else if (tx_tick) begin
        unique case (tx_st_ff)
          usdp_pkg::TX_IDLE:  tx_st_ff <= usdp_pkg::TX_IDLE;
          usdp_pkg::TX_START: tx_st_ff <= usdp_pkg::TX_DATA;
          usdp_pkg::TX_DATA: begin
            // LSB first, one bit per tick
            txsh_ff   <= txsh_ff >> 1;
            tx_bit_ff <= tx_bit_ff + 4'h1;
            if (tx_bit_ff == nbits - 4'h1) begin
              tx_st_ff <= parity_mode_field_ff[1] ? usdp_pkg::TX_PAR
                                                  : usdp_pkg::TX_STOP1;
            end
          end
          usdp_pkg::TX_PAR:   tx_st_ff <= usdp_pkg::TX_STOP1;
          usdp_pkg::TX_STOP1: tx_st_ff <= stop2_ff ? usdp_pkg::TX_STOP2
                                                   : usdp_pkg::TX_IDLE;
          usdp_pkg::TX_STOP2: tx_st_ff <= usdp_pkg::TX_IDLE;
          default:            tx_st_ff <= usdp_pkg::TX_IDLE;
        endcase
      end
    end
  end

  // Parity of the frame in flight
  logic tx_par_ff;
  always_ff @(posedge core_clk) begin
    if (!resetn)      tx_par_ff <= 1'b0;
    else if (tx_load) tx_par_ff <= par_bit(txbuf_ff, nbits, parity_mode_field_ff[0]);
  end

  // Pin level and ownership
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      serial_out_pin <= 1'b1;
      serial_out_oe  <= 1'b0;
      tx_on_ff       <= 1'b0;
    end else begin
      // Off only once enable is low and nothing is pending
      tx_on_ff <= transmitter_enable_ff || (tx_on_ff &&
                  (txbuf_valid_ff || (tx_st_ff != usdp_pkg::TX_IDLE)));
      serial_out_oe <= tx_on_ff;
      unique case (tx_st_ff)
        usdp_pkg::TX_START: serial_out_pin <= 1'b0;
        usdp_pkg::TX_DATA:  serial_out_pin <= txsh_ff[0];
        usdp_pkg::TX_PAR:   serial_out_pin <= tx_par_ff;
        default:            serial_out_pin <= 1'b1;
      endcase
    end
  end

  // Transmit complete flag: set wins over either clear
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tx_complete_flag_ff <= 1'b0;
    end else if (tx_frame_end && !txbuf_valid_ff) begin
      tx_complete_flag_ff <= 1'b1;
    end else if (irq_tx_complete_ack ||
                 (reg_wr && reg_addr == `USDP_ADDR_CSA && reg_wdata[`USDP_CSA_TXC])) begin
      tx_complete_flag_ff <= 1'b0;
    end
  end

  // Interrupt requests
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irq_tx_empty    <= 1'b0;
      irq_tx_complete <= 1'b0;
    end else begin
      irq_tx_empty    <= tx_buffer_empty_irq_en_ff && tx_buffer_empty_flag;
      irq_tx_complete <= tx_complete_irq_en_ff && tx_complete_flag_ff;
    end
  end

  // ==========================================================
  // Receiver
  usdp_pkg::usdp_rx_state_e rx_st_ff;
  logic [8:0]        rxsh_ff;        // Receive shift register
  logic [3:0]        rx_bit_ff;      // Data bits taken
  logic [BAUD_W+4:0] rx_cnt_ff;      // Sample timer
  logic [8:0]        rxbuf_ff;       // Receive buffer
  logic              rx_complete_flag_ff; // Unread data present
  logic              rx_tick;        // Sample point
  logic              rx_store;       // First stop bit reached
  logic              rx_in;          // Serial input when owned

  assign rx_in    = receiver_enable_ff ? serial_in_pin : 1'b1;
  assign rx_tick  = sync_mode_ff ? xck_fall : (rx_cnt_ff == '0);
  assign rx_store = rx_tick && (rx_st_ff == usdp_pkg::RX_STOP);

  // Receive sequencer
  always_ff @(posedge core_clk) begin
    if (!resetn || !receiver_enable_ff) begin
      rx_st_ff  <= usdp_pkg::RX_IDLE;
      rxsh_ff   <= 9'h000;
      rx_bit_ff <= 4'h0;
      rx_cnt_ff <= '0;
    end else begin
      rx_cnt_ff <= (rx_cnt_ff == '0) ? '0 : rx_cnt_ff - 1'b1;
      unique case (rx_st_ff)
        usdp_pkg::RX_IDLE: begin
          rx_bit_ff <= 4'h0;
          if (sync_mode_ff ? (xck_fall && !rx_in) : !rx_in) begin
            // Async waits half a bit to confirm the start bit
            rx_st_ff  <= sync_mode_ff ? usdp_pkg::RX_DATA : usdp_pkg::RX_START;
            rx_cnt_ff <= full_bit(double_speed_sel_ff, bit_period) >> 1;
          end
        end
        usdp_pkg::RX_START: if (rx_tick) begin
          rx_st_ff  <= rx_in ? usdp_pkg::RX_IDLE : usdp_pkg::RX_DATA;
          rx_cnt_ff <= full_bit(double_speed_sel_ff, bit_period) - 1'b1;
        end
        usdp_pkg::RX_DATA: if (rx_tick) begin
          rxsh_ff[rx_bit_ff] <= rx_in;
          rx_bit_ff <= rx_bit_ff + 4'h1;
          rx_cnt_ff <= full_bit(double_speed_sel_ff, bit_period) - 1'b1;
          if (rx_bit_ff == nbits - 4'h1) begin
            rx_st_ff <= parity_mode_field_ff[1] ? usdp_pkg::RX_PAR : usdp_pkg::RX_STOP;
          end
        end
        usdp_pkg::RX_PAR: if (rx_tick) begin
          rx_st_ff  <= usdp_pkg::RX_STOP;
          rx_cnt_ff <= full_bit(double_speed_sel_ff, bit_period) - 1'b1;
        end
        // Back to idle on the first stop bit; a second one is line idle
        usdp_pkg::RX_STOP: if (rx_tick) rx_st_ff <= usdp_pkg::RX_IDLE;
        default: rx_st_ff <= usdp_pkg::RX_IDLE;
      endcase
    end
  end

  // Receive buffer: store wins over a same-cycle read
  always_ff @(posedge core_clk) begin
    if (!resetn || !receiver_enable_ff) begin
      rxbuf_ff            <= 9'h000;
      rx_complete_flag_ff <= 1'b0;
    end else if (rx_store) begin
      rxbuf_ff            <= rxsh_ff & char_mask(nbits);
      rx_complete_flag_ff <= 1'b1;
    end else if (rd_data) begin
      rx_complete_flag_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Read port, data one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      reg_rdata    <= 8'h00;
      rx_pin_owned <= 1'b0;
    end else begin
      rx_pin_owned <= receiver_enable_ff;
      if (reg_rd) begin
        unique case (reg_addr)
          `USDP_ADDR_DATA: reg_rdata <= rxbuf_ff[7:0];
          `USDP_ADDR_CSA: reg_rdata <= {rx_complete_flag_ff, tx_complete_flag_ff,
                                        tx_buffer_empty_flag, 3'h0, double_speed_sel_ff, 1'b0};
          `USDP_ADDR_CSB: reg_rdata <= {1'b0, tx_complete_irq_en_ff,
                                        tx_buffer_empty_irq_en_ff, receiver_enable_ff,
                                        transmitter_enable_ff, char_size_code_ff[2],
                                        rxbuf_ff[8], tx_ninth_bit_ff};
          `USDP_ADDR_CSC: reg_rdata <= {1'b0, sync_mode_ff, parity_mode_field_ff,
                                        stop2_ff, char_size_code_ff[1:0], 1'b0};
          `USDP_ADDR_BAUD_LO: reg_rdata <= baud_ff[7:0];
          `USDP_ADDR_BAUD_HI: reg_rdata <= {{(16-BAUD_W){1'b0}}, baud_ff[BAUD_W-1:8]};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // Assertions
  sequence s_pending;
    txbuf_valid_ff && tx_on_ff && tx_st_ff == usdp_pkg::TX_IDLE;
  endsequence
  sequence s_short_read;
    rd_data && nbits < 4'h8 && !rx_store;
  endsequence

  a_buffer_moves: assert property (@(posedge core_clk) disable iff (!resetn)
    s_pending |=> tx_st_ff == usdp_pkg::TX_START ##1 !serial_out_pin)
    else $error("buffered data not moved to idle shifter");
  a_write_clears: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_data |=> !tx_buffer_empty_flag)
    else $error("data write did not clear empty flag");
  a_empty_request: assert property (@(posedge core_clk) disable iff (!resetn)
    tx_buffer_empty_irq_en_ff && tx_buffer_empty_flag |=> irq_tx_empty)
    else $error("empty request missing while flag set");
  a_complete_raise: assert property (@(posedge core_clk) disable iff (!resetn)
    tx_complete_irq_en_ff && $rose(tx_complete_flag_ff) |-> irq_tx_complete == 1'b0 ##1
    irq_tx_complete)
    else $error("complete request not raised with flag");
  a_disable_waits: assert property (@(posedge core_clk) disable iff (!resetn)
    tx_on_ff && !transmitter_enable_ff && txbuf_valid_ff |=> tx_on_ff ##1 serial_out_oe)
    else $error("transmitter released with data pending");
  a_idle_high: assert property (@(posedge core_clk) disable iff (!resetn)
    tx_on_ff && tx_st_ff == usdp_pkg::TX_IDLE |=> serial_out_pin && serial_out_oe)
    else $error("idle enabled line not driven high");
  a_pin_owned: assert property (@(posedge core_clk) disable iff (!resetn)
    ##1 rx_pin_owned == $past(receiver_enable_ff))
    else $error("receive pin ownership does not follow enable");
  a_read_clears: assert property (@(posedge core_clk) disable iff (!resetn)
    receiver_enable_ff && rd_data && !rx_store |=> !rx_complete_flag_ff)
    else $error("data read did not clear receive flag");
  a_store_sets: assert property (@(posedge core_clk) disable iff (!resetn)
    receiver_enable_ff && rx_store |=> rx_complete_flag_ff && rx_st_ff == usdp_pkg::RX_IDLE)
    else $error("first stop bit did not fill receive buffer");
  a_upper_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    s_short_read |=> (reg_rdata & ~char_mask(nbits)) == 8'h00)
    else $error("unused received bits not zero");
endmodule

//--- hw/usdp_defs.svh
`ifndef USDP_DEFS_SVH
`define USDP_DEFS_SVH
// Register offsets on the plain register port
`define USDP_ADDR_DATA    3'h0
`define USDP_ADDR_CSA     3'h1
`define USDP_ADDR_CSB     3'h2
`define USDP_ADDR_CSC     3'h3
`define USDP_ADDR_BAUD_LO 3'h4
`define USDP_ADDR_BAUD_HI 3'h5
// ctrl_status_a fields
`define USDP_CSA_RXC      7
`define USDP_CSA_TXC      6
`define USDP_CSA_TX_BUFFER_EMPTY_FLAG     5
`define USDP_CSA_U2X      1
// ctrl_status_b fields
`define USDP_CSB_TX_COMPLETE_IRQ_EN    6
`define USDP_CSB_TX_BUFFER_EMPTY_IRQ_EN    5
`define USDP_CSB_RECEIVER_ENABLE     4
`define USDP_CSB_TRANSMITTER_ENABLE     3
`define USDP_CSB_SZ2      2
`define USDP_CSB_RX_NINTH_BIT     1
`define USDP_CSB_TX_NINTH_BIT     0
// ctrl_status_c fields
`define USDP_CSC_SYNC     6
`define USDP_CSC_PAR_EN   5
`define USDP_CSC_PAR_ODD  4
`define USDP_CSC_STOP2    3
`define USDP_CSC_SZ_HI    2
`define USDP_CSC_SZ_LO    1
// Reset values
`define USDP_RST_SZ       3'h3
`define USDP_RST_BAUD     12'h000
// Samples per bit as shift amounts (16 and 8), normal and double speed
`define USDP_OVS_SHIFT_N  4
`define USDP_OVS_SHIFT_2X 3
// Character size code for nine data bits
`define USDP_SZ_NINE      3'h7
`endif

//--- hw/usdp_pkg.sv
package usdp_pkg;
  // Transmit sequencer states
  typedef enum logic [2:0] {
    TX_IDLE  = 3'h0,
    TX_START = 3'h1,
    TX_DATA  = 3'h2,
    TX_PAR   = 3'h3,
    TX_STOP1 = 3'h4,
    TX_STOP2 = 3'h5
  } usdp_tx_state_e;
  // Receive sequencer states
  typedef enum logic [2:0] {
    RX_IDLE  = 3'h0,
    RX_START = 3'h1,
    RX_DATA  = 3'h2,
    RX_PAR   = 3'h3,
    RX_STOP  = 3'h4
  } usdp_rx_state_e;
endpackage

//--- test/usdp_remote.sv
`timescale 1ns/1ps
// ==========================================
// Remote station: decodes our line, drives the receive line
module usdp_remote #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic        core_clk,
  input  wire logic        line_in,
  input  wire logic        line_oe,
  input  wire logic [3:0]  nb,
  input  wire logic        pe,
  input  wire logic        po,
  output logic             line_out,
  output logic [10:0]      word,
  output logic             word_stb
);
  initial begin
    line_out = 1'b1;
    word     = '0;
    word_stb = 1'b0;
  end
  // Mid-bit sampling; the first stop bit lands in the word too
  initial forever begin
    @(posedge core_clk);
    if (line_oe && !line_in) begin
      word <= '0;
      repeat (BIT_CLKS / 2) @(posedge core_clk);
      for (int i = 0; i <= nb + pe; i++) begin
        repeat (BIT_CLKS) @(posedge core_clk);
        word[i] <= line_in;
      end
      word_stb <= 1'b1;
      @(posedge core_clk);
      word_stb <= 1'b0;
    end
  end
  // Send one frame, line idles high between frames
  task automatic send(input logic [8:0] d);
    logic p;
    p = po;
    line_out <= 1'b0;
    repeat (BIT_CLKS) @(posedge core_clk);
    for (int i = 0; i < nb; i++) begin
      line_out <= d[i];
      p ^= d[i];
      repeat (BIT_CLKS) @(posedge core_clk);
    end
    if (pe) begin
      line_out <= p;
      repeat (BIT_CLKS) @(posedge core_clk);
    end
    line_out <= 1'b1;
    repeat (BIT_CLKS) @(posedge core_clk);
  endtask
endmodule

//--- test/tb_top.sv
`timescale 1ns/1ps
`include "usdp_defs.svh"
// ==========================================
// Top bench: register master, frame scoreboard
module tb_top;
  logic        core_clk, resetn, reg_wr, reg_rd, ack, sin, sout, soe, own, ie, ic, stb;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata, rdata, v, csb;
  logic [10:0] word, fq[$];
  logic [8:0]  d;
  logic [3:0]  nb;
  logic [2:0]  sz;
  logic        pe, po;
  int          err_total, tests_run, cyc;
  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;
  usdp_datapath dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .irq_tx_empty(ie), .irq_tx_complete(ic), .irq_tx_complete_ack(ack),
    .sync_clock_pin(1'b0), .serial_in_pin(sin), .serial_out_pin(sout),
    .serial_out_oe(soe), .rx_pin_owned(own));
  usdp_remote rmt (.core_clk(core_clk), .line_in(sout), .line_oe(soe), .nb(nb),
    .pe(pe), .po(po), .line_out(sin), .word(word), .word_stb(stb));
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("errors=%0d compares=%0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Strobe for one edge, then one quiet edge
  task automatic wr(input logic [2:0] a, input logic [7:0] w);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [2:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    v = rdata;
  endtask
  // Poll a status bit with a bounded count
  task automatic wait_bit(input int b);
    int n;
    n = 0;
    v = '0;
    while (v[b] !== 1'b1 && n < 400) begin
      rd(`USDP_ADDR_CSA);
      n++;
    end
    if (n == 400) chk(11'h0, 11'h1);
  endtask
  function automatic logic [10:0] mk(input logic [8:0] x);
    logic [10:0] w;
    logic        p;
    w = '0;
    p = po;
    for (int i = 0; i < 9; i++) if (i < nb) begin
      w[i] = x[i];
      p ^= x[i];
    end
    if (pe) w[nb] = p;
    w[nb + pe] = 1'b1;
    return w;
  endfunction
  // Scoreboard: oldest expected frame against each decoded one
  always @(posedge core_clk) if (stb === 1'b1) begin
    if (fq.size() == 0) chk(word, 'x);
    else chk(word, fq.pop_front());
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    {resetn, reg_wr, reg_rd, ack, reg_addr, reg_wdata} = '0;
    {err_total, tests_run, cyc} = '0;
    void'($urandom(32'h005E));
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    chk({soe, sout, own}, 3'b010);
    rd(`USDP_ADDR_CSA);
    chk(v, 8'h20);
    rd(`USDP_ADDR_CSC);
    chk(v, 8'h06);
    rd(3'h6);
    chk(v, 8'h00);
    for (int k = 0; k < 5; k++) begin
      sz = (k == 4) ? 3'h7 : 3'(k + 3) & 3'h3;
      nb = (sz == 3'h7) ? 4'h9 : 4'(sz) + 4'h5;
      pe = (k == 1 || k == 2 || k == 4);
      po = k[0];
      csb = {5'b01111, sz[2], 2'b00};
      wr(`USDP_ADDR_CSC, {2'b00, pe, po, k[1], sz[1:0], 1'b0});
      wr(`USDP_ADDR_CSB, csb);
      // Enable lands one edge after the write, pin ownership one more after that
      repeat (2) @(posedge core_clk);
      chk({own, soe, sout, ie}, 4'hF);
      for (int j = 0; j < 2; j++) begin
        d = 9'($urandom);
        wr(`USDP_ADDR_CSB, csb | {7'h00, d[8]});
        fq.push_back(mk(d));
        wr(`USDP_ADDR_DATA, d[7:0]);
        if (j == 0) wait_bit(5);
      end
      rd(`USDP_ADDR_CSA);
      chk(v[5], 1'b0);
      wr(`USDP_ADDR_CSB, csb & 8'hF7);
      chk(soe, 1'b1);
      wait_bit(6);
      chk(ic, 1'b1);
      if (k[0]) begin
        ack <= 1'b1;
        @(posedge core_clk);
        ack <= 1'b0;
        @(posedge core_clk);
      end else wr(`USDP_ADDR_CSA, 8'h40);
      rd(`USDP_ADDR_CSA);
      chk({v[6], ic, soe}, 3'b000);
      d = 9'($urandom);
      rmt.send(d);
      wait_bit(7);
      rd(`USDP_ADDR_CSB);
      if (sz == 3'h7) chk(v[1], d[8]);
      rd(`USDP_ADDR_DATA);
      chk(v, d[7:0] & ((nb >= 8) ? 8'hFF : 8'hFF >> (8 - nb)));
      rd(`USDP_ADDR_CSA);
      chk(v[7], 1'b0);
    end
    chk(fq.size(), 0);
    close_out();
  end
endmodule
